// ===== gid_pkg.sv
package gid_pkg;

	// timing of the debounce step
	localparam int CLK_PERIOD_NS = 8;
	localparam int DEB_STEP_NS = 1000000;
	localparam int MS_TICK_CYCLES = DEB_STEP_NS / CLK_PERIOD_NS;

	// sizes
	localparam int NUM_CHAN = 5;
	localparam int NUM_SRC = 6;
	localparam int NUM_PINS = 32;
	localparam int SEL_W = 6;
	localparam int DEB_W = 6;
	localparam int KEYPAD_SRC = 5;

	// register indices; byte address is four times the index, decoded on paddr[13:2]
	localparam logic [31:0] IDX_SEL0 = 32'h50001400;
	localparam logic [31:0] IDX_SEL1 = 32'h50001402;
	localparam logic [31:0] IDX_SEL2 = 32'h50001404;
	localparam logic [31:0] IDX_SEL3 = 32'h50001406;
	localparam logic [31:0] IDX_SEL4 = 32'h50001408;
	localparam logic [31:0] IDX_DEBOUNCE = 32'h5000140c;
	localparam logic [31:0] IDX_CLEAR = 32'h5000140e;
	localparam logic [31:0] IDX_LEVEL = 32'h50001410;
	localparam logic [31:0] IDX_STATUS = 32'h50001420;
	localparam logic [31:0] IDX_MASK = 32'h50001422;

	// field positions
	localparam int SEL_LSB = 0;
	localparam int DEB_TIME_LSB = 0;
	localparam int DEB_CHAN_EN_LSB = 8;
	localparam int DEB_KEYPAD_EN_BIT = 13;
	localparam int CLR_KEYPAD_BIT = 5;
	localparam int LVL_ACTIVE_LOW_LSB = 0;
	localparam int LVL_WAIT_REL_LSB = 8;
	localparam logic [5:0] SEL_LAST_VALID = 6'h20;

	// writable bits of each register
	localparam logic [15:0] SEL_WMASK = 16'h003f;
	localparam logic [15:0] DEB_WMASK = 16'h3f3f;
	localparam logic [15:0] LVL_WMASK = 16'h1f1f;
	localparam logic [15:0] IRQ_WMASK = 16'h003f;

	// reset values
	localparam logic [5:0] RST_SEL = 6'h00;
	localparam logic [15:0] RST_DEBOUNCE = 16'h0000;
	localparam logic [15:0] RST_LEVEL = 16'h0000;
	localparam logic [5:0] RST_MASK = 6'h00;
	localparam logic [5:0] RST_STATUS = 6'h00;

endpackage

// ===== gid_debounce.sv
// one debounce filter, stepping in millisecond ticks
module gid_debounce (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ms_tick,
	input wire logic enable,
	input wire logic [gid_pkg::DEB_W-1:0] time_ms,
	input wire logic level_in,
	output logic level_out
);

	logic last;
	logic [gid_pkg::DEB_W-1:0] cnt;
	wire differs = level_in != level_out;
	wire changed = level_in != last;
	wire expired = cnt >= time_ms;

	// input seen one cycle back, to spot a bounce
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last <= 1'b0;
		end else begin
			last <= level_in;
		end
	end

	// restart on bounce
	// the count only moves on ms ticks, so the wait is N ms minus up to one tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (!enable || !differs || changed || expired) begin
			cnt <= '0;
		end else if (ms_tick) begin
			cnt <= cnt + 6'h01;
		end
	end

	// level passes after N ms
	// bypass with debounce off: output just follows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_out <= 1'b0;
		end else if (!enable) begin
			level_out <= level_in;
		end else if (differs && !changed && expired) begin
			level_out <= level_in;
		end
	end

endmodule

// ===== gid_top.sv
// pin interrupt source select, polarity, debounce and pending logic with an apb slave
//
// The APB register port was chosen for this implementation.
module gid_top #(
	parameter int MS_TICK_CYCLES = gid_pkg::MS_TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] port0_pins,
	input wire logic [5:0] port1_pins,
	input wire logic [9:0] port2_pins,
	input wire logic [7:0] port3_pins,
	input wire logic keypad_path,
	output logic [gid_pkg::NUM_CHAN-1:0] chan_irq,
	output logic keypad_interrupt,
	output logic irq
);

	localparam int NS = gid_pkg::NUM_SRC;
	localparam int NIN = gid_pkg::NUM_PINS + 1;

	// merge two bytes of a write under strobes and writable bits
	function automatic logic [15:0] merge_wr(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [15:0] wmask);
		logic [15:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
		return (old & ~lanes) | (wd[15:0] & lanes);
	endfunction

	function automatic logic sel_valid(input logic [gid_pkg::SEL_W-1:0] sel);
		return (sel != 6'h00) && (sel <= gid_pkg::SEL_LAST_VALID);
	endfunction

	// pin map across ports 0 to 3
	// the pin vector is ordered so that selector minus one is the bit number
	function automatic logic pin_pick(input logic [gid_pkg::NUM_PINS-1:0] pins,
		input logic [gid_pkg::SEL_W-1:0] sel);
		logic [4:0] idx;
		idx = 5'(sel - 6'h01);
		return sel_valid(sel) & pins[idx];
	endfunction

	// -------- synchronisers --------
	logic [NIN-1:0] sync1;
	logic [NIN-1:0] sync2;
	logic [NIN-1:0] sync3;
	logic [NIN-1:0] in_state;
	wire [NIN-1:0] raw_in = {keypad_path, port3_pins, port2_pins, port1_pins, port0_pins};
	wire [NIN-1:0] in_agree = ~(sync2 ^ sync3);

	// three-stage sync
	// a change is taken once the second and third stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			in_state <= '0;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync3 <= sync2;
			in_state <= (sync3 & in_agree) | (in_state & ~in_agree);
		end
	end

	wire [gid_pkg::NUM_PINS-1:0] pins = in_state[gid_pkg::NUM_PINS-1:0];
	wire keypad_level = in_state[gid_pkg::NUM_PINS];

	// -------- millisecond tick --------
	logic [31:0] tick_cnt;
	wire tick_end = tick_cnt == 32'(MS_TICK_CYCLES - 1);
	logic ms_tick;

	// free-running divider shared by every filter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= '0;
			ms_tick <= 1'b0;
		end else begin
			tick_cnt <= tick_end ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
			ms_tick <= tick_end;
		end
	end

	// -------- registers --------
	logic [gid_pkg::SEL_W-1:0] sel_reg [gid_pkg::NUM_CHAN];
	logic [15:0] deb_reg;
	logic [15:0] lvl_reg;
	logic [NS-1:0] mask_reg;
	logic [NS-1:0] pending;
	logic [NS-1:0] armed;

	// apb decode on the word address
	wire [11:0] word = paddr[13:2];
	wire setup_ph = psel && !penable;
	wire wr_ph = psel && penable && pwrite;
	wire hit_sel0 = word == gid_pkg::IDX_SEL0[11:0];
	wire hit_sel1 = word == gid_pkg::IDX_SEL1[11:0];
	wire hit_sel2 = word == gid_pkg::IDX_SEL2[11:0];
	wire hit_sel3 = word == gid_pkg::IDX_SEL3[11:0];
	wire hit_sel4 = word == gid_pkg::IDX_SEL4[11:0];
	wire hit_deb = word == gid_pkg::IDX_DEBOUNCE[11:0];
	wire hit_clr = word == gid_pkg::IDX_CLEAR[11:0];
	wire hit_lvl = word == gid_pkg::IDX_LEVEL[11:0];
	wire hit_stat = word == gid_pkg::IDX_STATUS[11:0];
	wire hit_mask = word == gid_pkg::IDX_MASK[11:0];
	wire [gid_pkg::NUM_CHAN-1:0] hit_sel = {hit_sel4, hit_sel3, hit_sel2, hit_sel1, hit_sel0};
	wire hit_any = (|hit_sel) | hit_deb | hit_clr | hit_lvl | hit_stat | hit_mask;

	// zero-wait slave: every access finishes in its first access cycle
	assign pready = 1'b1;

	// read mux; the clear register always reads zero
	wire [15:0] sel_rd = hit_sel0 ? 16'(sel_reg[0]) : hit_sel1 ? 16'(sel_reg[1]) :
		hit_sel2 ? 16'(sel_reg[2]) : hit_sel3 ? 16'(sel_reg[3]) : 16'(sel_reg[4]);
	wire [15:0] rd_mux = (|hit_sel) ? sel_rd :
		hit_deb ? deb_reg :
		hit_lvl ? lvl_reg :
		hit_stat ? 16'(pending) :
		hit_mask ? 16'(mask_reg) : 16'h0000;

	// read data and error are caught in the setup cycle, so they come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rd_mux};
			pslverr <= !hit_any;
		end
	end

	// select registers, one per channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < gid_pkg::NUM_CHAN; c++) begin
				sel_reg[c] <= gid_pkg::RST_SEL;
			end
		end else if (wr_ph) begin
			for (int c = 0; c < gid_pkg::NUM_CHAN; c++) begin
				if (hit_sel[c]) begin
					sel_reg[c] <= 6'(merge_wr(16'(sel_reg[c]), pwdata, pstrb, gid_pkg::SEL_WMASK));
				end
			end
		end
	end

	// debounce, level control and mask registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deb_reg <= gid_pkg::RST_DEBOUNCE;
			lvl_reg <= gid_pkg::RST_LEVEL;
			mask_reg <= gid_pkg::RST_MASK;
		end else if (wr_ph) begin
			if (hit_deb) begin
				deb_reg <= merge_wr(deb_reg, pwdata, pstrb, gid_pkg::DEB_WMASK);
			end
			if (hit_lvl) begin
				lvl_reg <= merge_wr(lvl_reg, pwdata, pstrb, gid_pkg::LVL_WMASK);
			end
			if (hit_mask) begin
				mask_reg <= 6'(merge_wr(16'(mask_reg), pwdata, pstrb, gid_pkg::IRQ_WMASK));
			end
		end
	end

	// -------- per-source detection --------
	wire [gid_pkg::DEB_W-1:0] deb_time = deb_reg[gid_pkg::DEB_TIME_LSB +: gid_pkg::DEB_W];
	wire [NS-1:0] deb_en = {deb_reg[gid_pkg::DEB_KEYPAD_EN_BIT],
		deb_reg[gid_pkg::DEB_CHAN_EN_LSB +: gid_pkg::NUM_CHAN]};
	// keypad path never waits for release here
	wire [NS-1:0] wait_rel = {1'b0, lvl_reg[gid_pkg::LVL_WAIT_REL_LSB +: gid_pkg::NUM_CHAN]};
	wire [gid_pkg::NUM_CHAN-1:0] act_low = lvl_reg[gid_pkg::LVL_ACTIVE_LOW_LSB +: gid_pkg::NUM_CHAN];
	wire [NS-1:0] src_active;
	wire [NS-1:0] deb_level;

	assign src_active[gid_pkg::KEYPAD_SRC] = keypad_level;
	for (genvar c = 0; c < gid_pkg::NUM_CHAN; c++) begin : g_chan
		wire pin_lvl = pin_pick(pins, sel_reg[c]);
		assign src_active[c] = sel_valid(sel_reg[c]) & (pin_lvl ^ act_low[c]);
	end

	// one filter per source, sharing the time field and the tick
	for (genvar s = 0; s < NS; s++) begin : g_deb
		gid_debounce u_deb (
			.pclk(pclk),
			.presetn(presetn),
			.ms_tick(ms_tick),
			.enable(deb_en[s]),
			.time_ms(deb_time),
			.level_in(src_active[s]),
			.level_out(deb_level[s])
		);
	end

	// -------- pending, clear and re-arm --------
	// write-one clear
	wire [NS-1:0] clr_by_reg = (wr_ph && hit_clr && pstrb[0]) ? pwdata[NS-1:0] : '0;
	wire [NS-1:0] clr_by_stat = (wr_ph && hit_stat && pstrb[0]) ? pwdata[NS-1:0] : '0;
	wire [NS-1:0] clr_any = clr_by_reg | clr_by_stat;
	wire [NS-1:0] set_req = deb_level & (armed | ~wait_rel);
	// an event in the cycle of its clear wins and stays pending
	wire [NS-1:0] next_pending = set_req | (pending & ~clr_any);
	// ready again once inactive
	// a taken request disarms, so with wait for release set a held input cannot refill the flag after a clear
	wire [NS-1:0] next_armed = ~deb_level | (armed & ~set_req);

	// pending flags and release tracking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= gid_pkg::RST_STATUS;
			armed <= '1;
		end else begin
			pending <= next_pending;
			armed <= next_armed;
		end
	end

	// -------- outputs --------
	assign chan_irq = pending[gid_pkg::NUM_CHAN-1:0];
	assign keypad_interrupt = pending[gid_pkg::KEYPAD_SRC];

	// combined request, registered so it never glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_pending & mask_reg);
		end
	end

endmodule

// ===== gid_top_assertions.sv
// port-level checks for the pin interrupt block
module gid_top_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [gid_pkg::NUM_CHAN-1:0] chan_irq,
	input wire logic keypad_interrupt,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access decode, seen as software sees it
	wire logic acc = psel && penable;
	wire logic [5:0] pend = {keypad_interrupt, chan_irq};
	wire logic clr_rd = acc && !pwrite && (paddr[13:2] == gid_pkg::IDX_CLEAR[11:0]);
	// bus answers and read data framing
	property p_ready; acc |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	property p_upper; acc && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read half not zero");
	property p_hold; !(psel && !penable) |=> $stable(prdata); endproperty
	a_hold: assert property (p_hold) else $error("prdata moved outside setup");
	property p_unmap; acc && paddr[13:2] == 12'h7ff |-> pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("no error on unmapped access");
	property p_mapped; acc && paddr[13:2] == gid_pkg::IDX_SEL0[11:0] |-> !pslverr; endproperty
	a_mapped: assert property (p_mapped) else $error("error on mapped access");
	property p_clr_zero; clr_rd |-> prdata == 32'h00000000; endproperty
	a_clr_zero: assert property (p_clr_zero) else $error("clear register read nonzero");
	// pending only drops after a write
	property p_sticky; !(acc && pwrite) |=> (pend & $past(pend)) == $past(pend); endproperty
	a_sticky: assert property (p_sticky) else $error("pending dropped without write");
	// the line never rises without a pending source
	property p_irq_src; irq |-> pend != 6'h00; endproperty
	a_irq_src: assert property (p_irq_src) else $error("irq without pending");
	property p_quiet; $rose(presetn) |-> pend == 6'h00 && !irq; endproperty
	a_quiet: assert property (p_quiet) else $error("request right after reset");
endmodule

bind gid_top gid_top_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.chan_irq(chan_irq), .keypad_interrupt(keypad_interrupt), .irq(irq));

// ===== testbench.sv
// register-level bench for the pin interrupt block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic keypad_path = 0;
	logic err;
	logic [31:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] pins = 0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic keypad_interrupt;
	logic irq;
	logic [4:0] chan_irq;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	// short tick keeps debounce runs brief
	gid_top #(.MS_TICK_CYCLES(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port0_pins(pins[7:0]), .port1_pins(pins[13:8]), .port2_pins(pins[23:14]),
		.port3_pins(pins[31:24]), .keypad_path(keypad_path), .chan_irq(chan_irq),
		.keypad_interrupt(keypad_interrupt), .irq(irq));
	initial forever #4 pclk = ~pclk;
	task automatic end_of_test();
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// cut a hang short
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; byte address is four times the index
	task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= idx << 2;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic sel_all(input logic [31:0] v);
		for (int i = 0; i < 5; i++)
			apb(1, gid_pkg::IDX_SEL0 + 2 * i, v);
	endtask
	initial begin
		int sv[10] = '{1, 8, 9, 14, 15, 24, 25, 32, 0, 33};
		logic e;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		repeat (4) @(posedge pclk);
		// reset values, writable fields, read-as-zero and unmapped places
		for (int i = 0; i < 5; i++) begin
			apb(0, gid_pkg::IDX_SEL0 + 2 * i, 0);
			chk(rd, 0);
		end
		apb(1, gid_pkg::IDX_DEBOUNCE, 32'h0000ffff);
		apb(0, gid_pkg::IDX_DEBOUNCE, 0);
		chk(rd, 32'h00003f3f);
		apb(1, gid_pkg::IDX_CLEAR, 32'h0000003f);
		apb(0, gid_pkg::IDX_CLEAR, 0);
		chk(rd, 0);
		apb(0, 32'h000007ff, 0);
		chk(err, 1);
		apb(1, gid_pkg::IDX_DEBOUNCE, 0);
		apb(1, gid_pkg::IDX_MASK, 1);
		// selector boundaries, then the no-pin codes with every pin high
		for (int i = 0; i < 10; i++) begin
			e = sv[i] inside {[1:32]};
			apb(1, gid_pkg::IDX_SEL0, sv[i]);
			pins <= e ? 32'h1 << (sv[i] - 1) : 32'hffffffff;
			repeat (10) @(posedge pclk);
			chk(chan_irq[0], e);
			chk(irq, e);
			pins <= 0;
			repeat (6) @(posedge pclk);
			apb(1, gid_pkg::IDX_CLEAR, 1);
			repeat (2) @(posedge pclk);
			chk(chan_irq[0], 0);
		end
		// every channel shares one encoding
		sel_all(1);
		pins <= 1;
		repeat (10) @(posedge pclk);
		chk(chan_irq, 5'h1f);
		pins <= 0;
		sel_all(0);
		apb(1, gid_pkg::IDX_CLEAR, 32'h1f);
		repeat (2) @(posedge pclk);
		chk(chan_irq, 0);
		// active-low source, status read, mask and write-one-to-clear
		apb(1, gid_pkg::IDX_SEL0, 1);
		apb(1, gid_pkg::IDX_LEVEL, 1);
		repeat (10) @(posedge pclk);
		chk(chan_irq[0], 1);
		apb(0, gid_pkg::IDX_STATUS, 0);
		chk(rd, 1);
		apb(1, gid_pkg::IDX_MASK, 0);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		apb(1, gid_pkg::IDX_MASK, 1);
		repeat (2) @(posedge pclk);
		chk(irq, 1);
		pins <= 1;
		repeat (6) @(posedge pclk);
		apb(1, gid_pkg::IDX_STATUS, 1);
		repeat (2) @(posedge pclk);
		chk(chan_irq[0], 0);
		chk(irq, 0);
		// wait for release before the next request
		apb(1, gid_pkg::IDX_LEVEL, 32'h100);
		repeat (10) @(posedge pclk);
		chk(chan_irq[0], 1);
		apb(1, gid_pkg::IDX_CLEAR, 1);
		repeat (4) @(posedge pclk);
		chk(chan_irq[0], 0);
		pins <= 0;
		repeat (8) @(posedge pclk);
		pins <= 1;
		repeat (10) @(posedge pclk);
		chk(chan_irq[0], 1);
		apb(1, gid_pkg::IDX_LEVEL, 0);
		// keypad debounced for 3 ms while channel 0 passes straight through
		pins <= 0;
		apb(1, gid_pkg::IDX_DEBOUNCE, 32'h2003);
		apb(1, gid_pkg::IDX_CLEAR, 1);
		pins <= 1;
		keypad_path <= 1;
		repeat (10) @(posedge pclk);
		chk(chan_irq[0], 1);
		chk(keypad_interrupt, 0);
		repeat (30) @(posedge pclk);
		chk(keypad_interrupt, 1);
		keypad_path <= 0;
		pins <= 0;
		repeat (50) @(posedge pclk);
		apb(1, gid_pkg::IDX_CLEAR, 32'h21);
		repeat (2) @(posedge pclk);
		chk(keypad_interrupt, 0);
		// channel 0 debounced on its own enable
		apb(1, gid_pkg::IDX_DEBOUNCE, 32'h0103);
		pins <= 1;
		repeat (10) @(posedge pclk);
		chk(chan_irq[0], 0);
		repeat (30) @(posedge pclk);
		chk(chan_irq[0], 1);
		// a bounce inside the debounce time restarts the count
		pins <= 0;
		repeat (50) @(posedge pclk);
		apb(1, gid_pkg::IDX_CLEAR, 1);
		repeat (2) @(posedge pclk);
		chk(chan_irq[0], 0);
		pins <= 1;
		repeat (12) @(posedge pclk);
		pins <= 0;
		repeat (6) @(posedge pclk);
		pins <= 1;
		repeat (20) @(posedge pclk);
		chk(chan_irq[0], 0);
		repeat (30) @(posedge pclk);
		chk(chan_irq[0], 1);
		end_of_test();
	end
endmodule
